// ===== inc/ldcb_pkg.sv
// constants for the per-unit configuration register bank
// assumes the bank sits behind the configuration index/data ports
package ldcb_pkg;

	// unit slots held by the bank
	localparam int NUM_UNITS = 7;
	localparam logic [2:0] U_FLOPPY = 3'h0;
	localparam logic [2:0] U_PAR = 3'h1;
	localparam logic [2:0] U_SER1 = 3'h2;
	localparam logic [2:0] U_SER2 = 3'h3;
	localparam logic [2:0] U_KEYB = 3'h4;
	localparam logic [2:0] U_AUX = 3'h5;
	localparam logic [2:0] U_ACPI = 3'h6;
	localparam logic [2:0] U_NONE = 3'h7;

	// logical device numbers selecting each slot
	localparam logic [7:0] LDN_FLOPPY = 8'h00;
	localparam logic [7:0] LDN_PAR = 8'h03;
	localparam logic [7:0] LDN_SER1 = 8'h04;
	localparam logic [7:0] LDN_SER2 = 8'h05;
	localparam logic [7:0] LDN_KEYB = 8'h07;
	localparam logic [7:0] LDN_AUX = 8'h08;
	localparam logic [7:0] LDN_ACPI = 8'h0A;

	// register indices
	localparam logic [7:0] IDX_ACTIVATE = 8'h30;
	localparam logic [7:0] IDX_BASE0_HI = 8'h60;
	localparam logic [7:0] IDX_BASE0_LO = 8'h61;
	localparam logic [7:0] IDX_BASE1_HI = 8'h62;
	localparam logic [7:0] IDX_BASE1_LO = 8'h63;
	localparam logic [7:0] IDX_IRQ_PRI = 8'h70;
	localparam logic [7:0] IDX_IRQ_SEC = 8'h72;
	localparam logic [7:0] IDX_DMA_SEL = 8'h74;

	// reset values and fields
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [3:0] RST_IRQ = 4'h0;
	localparam logic [7:0] RST_DMA = 8'h04;
	localparam int ACT_BIT = 0;
	localparam int IRQ_W = 4;

	// which slots own which optional registers (bit = slot)
	localparam logic [6:0] HAS_BASE0 = 7'h4F;
	localparam logic [6:0] HAS_BASE1 = 7'h00;
	localparam logic [6:0] HAS_IRQ_SEC = 7'h10;
	localparam logic [6:0] HAS_DMA = 7'h0B;

	// power-control bit positions for linked slots
	localparam int PWR_FLOPPY = 0;
	localparam int PWR_PAR = 3;
	localparam int PWR_SER1 = 4;
	localparam int PWR_SER2 = 5;

	// permitted base ranges, alignment and decoded span
	localparam logic [11:0] DEC_MASK = 12'hFFF;
	localparam logic [15:0] BASE_MIN = 16'h0100;
	localparam logic [15:0] BASE_MAX = 16'h0FF8;
	localparam logic [15:0] BASE_MAX_PAR = 16'h0FFC;
	localparam logic [15:0] ACPI_MIN = 16'h0000;
	localparam logic [15:0] ACPI_MAX = 16'h0FE7;
	localparam int ALIGN_STD = 8;
	localparam int ALIGN_PAR = 4;
	localparam int ALIGN_ACPI = 24;
	localparam logic [12:0] SPAN_STD = 13'h0008;
	localparam logic [12:0] SPAN_ACPI = 13'h0018;
	localparam logic [11:0] KEYB_DATA = 12'h060;
	localparam logic [11:0] KEYB_CMD = 12'h064;

endpackage

// ===== rtl/ldcb_bank.sv
// banked per-unit configuration registers, seven unit slots
// assumes port strobes come from logic on i_mclk; host reset is a pin
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
module ldcb_bank
	import ldcb_pkg::*;
(
	input wire logic i_mclk, // 20 MHz clock
	input wire logic i_rst_n, // standby power-on reset
	input wire logic i_host_reset, // host reset pin, high
	input wire logic i_cfg_mode, // configuration state level
	input wire logic [7:0] i_ldn, // logical device number
	input wire logic i_idx_wr, // index port write pulse
	input wire logic i_data_wr, // data port write pulse
	input wire logic i_data_rd, // data port read pulse
	input wire logic [7:0] i_wdata, // host write byte
	input wire logic i_pwr_wr, // power register write pulse
	input wire logic [7:0] i_pwr_wdata, // power register byte
	input wire logic i_io_cycle, // host i/o cycle pulse
	input wire logic [15:0] i_io_addr, // host i/o address
	output logic [7:0] o_rdata, // data port read byte
	output logic o_rvalid, // read byte valid pulse
	output logic [6:0] o_unit_on, // unit active/powered
	output logic [7:0] o_pwr_bits, // power bits mirror
	output logic [6:0] o_unit_hit, // i/o cycle hits unit
	output logic [27:0] o_irq_level, // irq line per unit
	output logic [3:0] o_irq_level_sec, // keyboard second irq
	output logic [23:0] o_dma_sel, // dma select, slots 0,1,3
	output logic o_irq_edge_high // irq signalling polarity
);

	////////////////////////////////////////////////////////////////
	// helpers

	// map device number to slot
	function automatic logic [2:0] slot_of(input logic [7:0] ldn);
		case (ldn)
			LDN_FLOPPY: slot_of = U_FLOPPY;
			LDN_PAR: slot_of = U_PAR;
			LDN_SER1: slot_of = U_SER1;
			LDN_SER2: slot_of = U_SER2;
			LDN_KEYB: slot_of = U_KEYB;
			LDN_AUX: slot_of = U_AUX;
			LDN_ACPI: slot_of = U_ACPI;
			default: slot_of = U_NONE;
		endcase
	endfunction

	// base inside its permitted range and alignment
	function automatic logic base_ok(input int u, input logic [15:0] b);
		logic ok;
		ok = 1'b0;
		if (u == int'(U_ACPI)) begin
			ok = (b >= ACPI_MIN) && (b <= ACPI_MAX) && ((b % ALIGN_ACPI) == 0);
		end else if (u == int'(U_PAR)) begin
			ok = (b >= BASE_MIN) && (b <= BASE_MAX_PAR) && ((b % ALIGN_PAR) == 0);
		end else if (HAS_BASE0[u]) begin
			ok = (b >= BASE_MIN) && (b <= BASE_MAX) && ((b % ALIGN_STD) == 0);
		end
		return ok;
	endfunction

	////////////////////////////////////////////////////////////////
	// storage

	logic hr_s1_ff, hr_s2_ff, hr_s3_ff; // host reset synchroniser
	logic hr_ff; // filtered host reset level
	logic [7:0] idx_ff; // index port
	logic [6:0] act_ff; // activate/power bits
	logic [7:0] b0h_ff [NUM_UNITS]; // base 0 high bytes
	logic [7:0] b0l_ff [NUM_UNITS]; // base 0 low bytes
	logic [7:0] b1h_ff [NUM_UNITS]; // base 1 high bytes
	logic [7:0] b1l_ff [NUM_UNITS]; // base 1 low bytes
	logic [3:0] irq_ff [NUM_UNITS]; // primary irq levels
	logic [3:0] irq2_ff; // keyboard second irq level
	logic [7:0] dma_ff [NUM_UNITS]; // dma selects
	logic [7:0] rdata_ff; // read byte
	logic rvalid_ff; // read pulse
	logic [7:0] pwr_ff; // power bits mirror
	logic [6:0] hit_ff; // decoded unit hits
	logic edge_high_ff; // irq polarity flag

	// access qualifiers
	logic [2:0] sel; // bank chosen at this access
	logic wr_ok, rd_ok; // qualified data strobes
	logic [7:0] nxt_rdata; // read mux

	assign sel = slot_of(i_ldn);
	assign wr_ok = i_data_wr && i_cfg_mode && (sel != U_NONE);
	assign rd_ok = i_data_rd && i_cfg_mode;

	////////////////////////////////////////////////////////////////
	// host reset pin synchroniser, three stages

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hr_s1_ff <= 1'b0;
			hr_s2_ff <= 1'b0;
			hr_s3_ff <= 1'b0;
			hr_ff <= 1'b0;
		end else begin
			hr_s1_ff <= i_host_reset;
			hr_s2_ff <= hr_s1_ff;
			hr_s3_ff <= hr_s2_ff;
			// accept a change once stages two and three agree
			if (hr_s2_ff == hr_s3_ff) begin
				hr_ff <= hr_s3_ff;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// index port

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			idx_ff <= RST_BYTE;
		end else if (hr_ff) begin
			idx_ff <= RST_BYTE;
		end else if (i_idx_wr && i_cfg_mode) begin
			idx_ff <= i_wdata;
		end
	end

	////////////////////////////////////////////////////////////////
	// activate bits, shared with the power-control bits

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			act_ff <= '0; // standby reset clears every slot
		end else begin
			if (hr_ff) begin
				// ordinary reset spares the second serial port
				for (int u = 0; u < NUM_UNITS; u++) begin
					if (u != int'(U_SER2)) begin
						act_ff[u] <= 1'b0;
					end
				end
			end else begin
				// power writes move the linked activate bits
				if (i_pwr_wr) begin
					act_ff[U_FLOPPY] <= i_pwr_wdata[PWR_FLOPPY];
					act_ff[U_PAR] <= i_pwr_wdata[PWR_PAR];
					act_ff[U_SER1] <= i_pwr_wdata[PWR_SER1];
					act_ff[U_SER2] <= i_pwr_wdata[PWR_SER2];
				end
				// a host activate write lands last
				if (wr_ok && idx_ff == IDX_ACTIVATE) begin
					act_ff[sel] <= i_wdata[ACT_BIT];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// base, irq and dma registers of the selected bank

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int u = 0; u < NUM_UNITS; u++) begin
				b0h_ff[u] <= RST_BYTE;
				b0l_ff[u] <= RST_BYTE;
				b1h_ff[u] <= RST_BYTE;
				b1l_ff[u] <= RST_BYTE;
				irq_ff[u] <= RST_IRQ;
				dma_ff[u] <= RST_DMA;
			end
			irq2_ff <= RST_IRQ;
		end else if (hr_ff) begin
			for (int u = 0; u < NUM_UNITS; u++) begin
				b0h_ff[u] <= RST_BYTE;
				b0l_ff[u] <= RST_BYTE;
				b1h_ff[u] <= RST_BYTE;
				b1l_ff[u] <= RST_BYTE;
				irq_ff[u] <= RST_IRQ;
				dma_ff[u] <= RST_DMA;
			end
			irq2_ff <= RST_IRQ;
		end else if (wr_ok) begin
			// unowned registers drop the write
			case (idx_ff)
				IDX_BASE0_HI: if (HAS_BASE0[sel]) begin
					b0h_ff[sel] <= i_wdata;
				end
				IDX_BASE0_LO: if (HAS_BASE0[sel]) begin
					b0l_ff[sel] <= i_wdata;
				end
				IDX_BASE1_HI: if (HAS_BASE1[sel]) begin
					b1h_ff[sel] <= i_wdata;
				end
				IDX_BASE1_LO: if (HAS_BASE1[sel]) begin
					b1l_ff[sel] <= i_wdata;
				end
				IDX_IRQ_PRI: begin
					irq_ff[sel] <= i_wdata[IRQ_W-1:0];
				end
				IDX_IRQ_SEC: if (HAS_IRQ_SEC[sel]) begin
					irq2_ff <= i_wdata[IRQ_W-1:0];
				end
				IDX_DMA_SEL: if (HAS_DMA[sel]) begin
					dma_ff[sel] <= i_wdata;
				end
				// reserved and unimplemented indices ignore writes
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// read mux: unowned and reserved indices give zero

	always_comb begin
		nxt_rdata = RST_BYTE;
		if (sel != U_NONE) begin
			case (idx_ff)
				IDX_ACTIVATE: nxt_rdata = {7'h00, act_ff[sel]};
				IDX_BASE0_HI: nxt_rdata = HAS_BASE0[sel] ? b0h_ff[sel] : RST_BYTE;
				IDX_BASE0_LO: nxt_rdata = HAS_BASE0[sel] ? b0l_ff[sel] : RST_BYTE;
				IDX_BASE1_HI: nxt_rdata = HAS_BASE1[sel] ? b1h_ff[sel] : RST_BYTE;
				IDX_BASE1_LO: nxt_rdata = HAS_BASE1[sel] ? b1l_ff[sel] : RST_BYTE;
				IDX_IRQ_PRI: nxt_rdata = {4'h0, irq_ff[sel]};
				IDX_IRQ_SEC: nxt_rdata = HAS_IRQ_SEC[sel] ? {4'h0, irq2_ff} : RST_BYTE;
				IDX_DMA_SEL: nxt_rdata = HAS_DMA[sel] ? dma_ff[sel] : RST_BYTE;
				default: nxt_rdata = RST_BYTE;
			endcase
		end
	end

	// read byte and its pulse
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_ff <= RST_BYTE;
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= rd_ok;
			if (rd_ok) begin
				rdata_ff <= nxt_rdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// status mirrors: power bits and irq polarity flag

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pwr_ff <= RST_BYTE;
			edge_high_ff <= 1'b1;
		end else begin
			pwr_ff <= RST_BYTE;
			pwr_ff[PWR_FLOPPY] <= act_ff[U_FLOPPY];
			pwr_ff[PWR_PAR] <= act_ff[U_PAR];
			pwr_ff[PWR_SER1] <= act_ff[U_SER1];
			pwr_ff[PWR_SER2] <= act_ff[U_SER2];
			edge_high_ff <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// i/o decode per unit on address bits 11:0

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hit_ff <= '0;
		end else begin
			for (int u = 0; u < NUM_UNITS; u++) begin
				logic [15:0] b;
				logic [12:0] off;
				logic [12:0] span;
				b = {b0h_ff[u], b0l_ff[u]};
				off = {1'b0, i_io_addr[11:0] & DEC_MASK} - {1'b0, b[11:0] & DEC_MASK};
				span = (u == int'(U_ACPI)) ? SPAN_ACPI : SPAN_STD;
				if (u == int'(U_KEYB)) begin
					// keyboard sits at fixed ports
					hit_ff[u] <= i_io_cycle && act_ff[u]
						&& (i_io_addr[11:0] == KEYB_DATA || i_io_addr[11:0] == KEYB_CMD);
				end else begin
					// a base out of range blocks the unit
					hit_ff[u] <= i_io_cycle && act_ff[u] && base_ok(u, b)
						&& (i_io_addr[11:0] >= b[11:0]) && (off < span);
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs, all from flops

	assign o_rdata = rdata_ff;
	assign o_rvalid = rvalid_ff;
	assign o_unit_on = act_ff;
	assign o_pwr_bits = pwr_ff;
	assign o_unit_hit = hit_ff;
	assign o_irq_level = {irq_ff[6], irq_ff[5], irq_ff[4], irq_ff[3], irq_ff[2], irq_ff[1], irq_ff[0]};
	assign o_irq_level_sec = irq2_ff;
	assign o_dma_sel = {dma_ff[U_SER2], dma_ff[U_PAR], dma_ff[U_FLOPPY]};
	assign o_irq_edge_high = edge_high_ff;

endmodule

// ===== sim/ldcb_bank_chk.sv
// port assertions for the per-unit configuration bank
// assumes it is bound onto every ldcb_bank instance
`timescale 1ns/1ps
module ldcb_bank_chk (
	input logic i_mclk,
	input logic i_rst_n,
	input logic i_cfg_mode,
	input logic i_data_rd,
	input logic i_pwr_wr,
	input logic [7:0] i_pwr_wdata,
	input logic i_io_cycle,
	input logic [15:0] i_io_addr,
	input logic o_rvalid,
	input logic [6:0] o_unit_on,
	input logic [7:0] o_pwr_bits,
	input logic [6:0] o_unit_hit,
	input logic [27:0] o_irq_level,
	input logic [3:0] o_irq_level_sec,
	input logic [23:0] o_dma_sel,
	input logic o_irq_edge_high
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	////////////////////////////////////////////////////////////////////////
	// data port answers only in configuration state
	a_read_answer: assert property (i_data_rd && i_cfg_mode |=> o_rvalid)
		else $error("read not answered");
	a_read_refused: assert property (!(i_data_rd && i_cfg_mode) |=> !o_rvalid)
		else $error("read answered outside state");
	// power link drives activate, mirror follows
	a_pwr_link: assert property (i_pwr_wr |=> o_unit_on[3:0] ==
		{$past(i_pwr_wdata[5]), $past(i_pwr_wdata[4]), $past(i_pwr_wdata[3]), $past(i_pwr_wdata[0])})
		else $error("power write not linked");
	a_pwr_mirror: assert property (i_pwr_wr |=> ##1 o_pwr_bits[5:3] == $past(i_pwr_wdata[5:3], 2)
		&& o_pwr_bits[0] == $past(i_pwr_wdata[0], 2)) else $error("power mirror wrong");
	// fixed settings and reset values
	a_edge_high: assert property (o_irq_edge_high) else $error("irq polarity wrong");
	a_reset_vals: assert property ($rose(i_rst_n) |-> o_irq_level == 28'h0
		&& o_irq_level_sec == 4'h0 && o_dma_sel == 24'h040404) else $error("reset values wrong");
	// decode needs a cycle and an active unit
	a_hit_cause: assert property (|o_unit_hit |-> $past(i_io_cycle)) else $error("hit without cycle");
	a_hit_active: assert property ((o_unit_hit & ~$past(o_unit_on)) == 7'h00)
		else $error("hit on inactive unit");
	a_keyb_fixed: assert property (i_io_cycle && i_io_addr[11:0] == 12'h060 && o_unit_on[4]
		|=> o_unit_hit[4]) else $error("keyboard port missed");
endmodule
bind ldcb_bank ldcb_bank_chk chk (.i_mclk, .i_rst_n, .i_cfg_mode, .i_data_rd, .i_pwr_wr, .i_pwr_wdata,
	.i_io_cycle, .i_io_addr, .o_rvalid, .o_unit_on, .o_pwr_bits, .o_unit_hit, .o_irq_level,
	.o_irq_level_sec, .o_dma_sel, .o_irq_edge_high);

// ===== sim/ldcb_host.sv
// host model driving the configuration index and data ports
// assumes the bench calls its tasks; strobes change on falling edges
`timescale 1ns/1ps
module ldcb_host (
	input logic i_mclk,
	input logic i_rvalid,
	input logic [7:0] i_rdata,
	output logic o_cfg_mode,
	output logic [7:0] o_ldn,
	output logic o_idx_wr,
	output logic o_data_wr,
	output logic o_data_rd,
	output logic [7:0] o_wdata
);
	initial begin
		{o_cfg_mode, o_ldn, o_idx_wr, o_data_wr, o_data_rd, o_wdata} = '0;
	end
	////////////////////////////////////////////////////////////////////////
	// one strobe for one cycle, then the data line shows the inverse
	task automatic put(input logic [7:0] d, input logic [2:0] k);
		@(negedge i_mclk);
		{o_idx_wr, o_data_wr, o_data_rd} = k;
		o_wdata = d;
		@(negedge i_mclk);
		{o_idx_wr, o_data_wr, o_data_rd} = 3'h0;
		o_wdata = ~d;
	endtask
	// enter or leave configuration state, pick the unit
	task automatic mode(input logic m, input logic [7:0] l);
		@(negedge i_mclk);
		o_cfg_mode = m;
		o_ldn = l;
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		put(i, 3'h4);
		put(d, 3'h2);
	endtask
	task automatic rd(input logic [7:0] i, output logic [7:0] d);
		int n;
		put(i, 3'h4);
		put(8'h00, 3'h1);
		d = 'x;
		for (n = 0; n < 4 && i_rvalid !== 1'b1; n++) @(negedge i_mclk);
		if (i_rvalid === 1'b1) d = i_rdata;
	endtask
endmodule

// ===== sim/tb_top.sv
// self-checking bench for the per-unit configuration bank
// assumes ldcb_host drives the configuration ports
`timescale 1ns/1ps
module tb_top;
	import ldcb_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic host_rst = 1'b0;
	logic pwr_wr = 1'b0;
	logic [7:0] pwr_wdata = 8'h00;
	logic io_cyc = 1'b0;
	logic [15:0] io_addr = 16'h0000;
	logic cfg, idx_wr, data_wr, data_rd, rvalid, edge_high;
	logic [7:0] ldn, wdata, rdata, pwr_bits, d;
	logic [6:0] on, hit;
	logic [27:0] irq;
	logic [3:0] irq2;
	logic [23:0] dma;
	int err_total = 0;
	int num_checks = 0;
	logic [7:0] ldns [7] = '{LDN_FLOPPY, LDN_PAR, LDN_SER1, LDN_SER2, LDN_KEYB, LDN_AUX, LDN_ACPI};
	logic [7:0] rsv [11] = '{8'h31, 8'h3F, 8'h40, 8'h5F, 8'h62, 8'h63, 8'h71, 8'h73, 8'h75, 8'h76, 8'hDF};
	always #25 mclk = ~mclk;
	ldcb_host host (.i_mclk(mclk), .i_rvalid(rvalid), .i_rdata(rdata), .o_cfg_mode(cfg), .o_ldn(ldn),
		.o_idx_wr(idx_wr), .o_data_wr(data_wr), .o_data_rd(data_rd), .o_wdata(wdata));
	ldcb_bank dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_host_reset(host_rst), .i_cfg_mode(cfg), .i_ldn(ldn),
		.i_idx_wr(idx_wr), .i_data_wr(data_wr), .i_data_rd(data_rd), .i_wdata(wdata), .i_pwr_wr(pwr_wr),
		.i_pwr_wdata(pwr_wdata), .i_io_cycle(io_cyc), .i_io_addr(io_addr), .o_rdata(rdata), .o_rvalid(rvalid),
		.o_unit_on(on), .o_pwr_bits(pwr_bits), .o_unit_hit(hit), .o_irq_level(irq), .o_irq_level_sec(irq2),
		.o_dma_sel(dma), .o_irq_edge_high(edge_high));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rc(input logic [7:0] i, input logic [7:0] e);
		host.rd(i, d);
		chk("rdata", 32'(e), 32'(d));
	endtask
	task automatic pwr(input logic [7:0] v);
		@(negedge mclk);
		pwr_wr = 1'b1;
		pwr_wdata = v;
		@(negedge mclk);
		pwr_wr = 1'b0;
	endtask
	task automatic io(input logic [15:0] a, input logic [6:0] e);
		@(negedge mclk);
		io_cyc = 1'b1;
		io_addr = a;
		@(negedge mclk);
		io_cyc = 1'b0;
		chk("hit", 32'(e), 32'(hit));
	endtask
	task automatic test_done;
		if (err_total == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		int s;
		repeat (2) @(negedge mclk);
		rst_n = 1'b1;
		for (s = 0; s < 7; s++) begin
			host.mode(1'b1, ldns[s]);
			rc(IDX_DMA_SEL, (s < 2 || s == 3) ? 8'h04 : 8'h00);
			rc(IDX_IRQ_PRI, 8'h00);
			host.wr(IDX_IRQ_PRI, 8'hF0 | 8'(s));
			host.wr(IDX_IRQ_SEC, 8'h0A);
			rc(IDX_IRQ_SEC, (s == 4) ? 8'h0A : 8'h00);
			host.wr(IDX_BASE0_HI, 8'h03);
			rc(IDX_BASE0_HI, (s == 4 || s == 5) ? 8'h00 : 8'h03);
		end
		for (s = 0; s < 7; s++) begin
			host.mode(1'b1, ldns[s]);
			rc(IDX_IRQ_PRI, 8'(s));
			chk("irq", 32'(s), 32'(irq[4*s +: 4]));
		end
		chk("irq2", 32'h0A, 32'(irq2));
		chk("edge", 32'h1, 32'(edge_high));
		host.mode(1'b1, LDN_FLOPPY);
		foreach (rsv[k]) begin
			host.wr(rsv[k], 8'hFF);
			rc(rsv[k], 8'h00);
		end
		host.wr(IDX_BASE0_LO, 8'hF0);
		rc(IDX_BASE0_LO, 8'hF0);
		host.wr(IDX_ACTIVATE, 8'hFF);
		rc(IDX_ACTIVATE, 8'h01);
		chk("pwr", 32'h1, 32'(pwr_bits[0]));
		// floppy dma select takes a full byte
		host.wr(IDX_DMA_SEL, 8'h02);
		rc(IDX_DMA_SEL, 8'h02);
		chk("dma", 32'h040402, 32'(dma));
		io(16'h03F0, 7'h01);
		io(16'hF3F4, 7'h01);
		// serial 1 active but based below the permitted range
		host.mode(1'b1, LDN_SER1);
		host.wr(IDX_BASE0_HI, 8'h00);
		host.wr(IDX_BASE0_LO, 8'h50);
		host.wr(IDX_ACTIVATE, 8'h01);
		io(16'h0050, 7'h00);
		host.mode(1'b1, LDN_KEYB);
		host.wr(IDX_ACTIVATE, 8'h01);
		io(16'h0064, 7'h10);
		io(16'h0060, 7'h10);
		// parallel port may sit on a four byte boundary
		host.mode(1'b1, LDN_PAR);
		host.wr(IDX_BASE0_LO, 8'h7C);
		host.wr(IDX_ACTIVATE, 8'h01);
		io(16'h037C, 7'h02);
		pwr(8'h20);
		chk("on", 32'h18, 32'(on));
		// write outside configuration state must not land
		host.mode(1'b0, LDN_SER2);
		host.wr(IDX_ACTIVATE, 8'h00);
		host.mode(1'b1, LDN_SER2);
		rc(IDX_ACTIVATE, 8'h01);
		@(negedge mclk);
		host_rst = 1'b1;
		repeat (8) @(negedge mclk);
		host_rst = 1'b0;
		repeat (8) @(negedge mclk);
		chk("on", 32'h08, 32'(on));
		chk("dma", 32'h040404, 32'(dma));
		rc(IDX_IRQ_PRI, 8'h00);
		chk("irq", 32'h0, 32'(irq));
		chk("irq2", 32'h0, 32'(irq2));
		// serial 2 dma select moved, then the standby reset restores it
		host.wr(IDX_DMA_SEL, 8'h01);
		rc(IDX_DMA_SEL, 8'h01);
		rst_n = 1'b0;
		@(negedge mclk);
		rst_n = 1'b1;
		chk("on", 32'h0, 32'(on));
		rc(IDX_DMA_SEL, 8'h04);
		chk("dma", 32'h040404, 32'(dma));
		test_done();
	end
	// watchdog well beyond the few hundred cycles the tests take
	initial begin
		#1000000;
		err_total++;
		test_done();
	end
endmodule
